// ===== pkg/irp_pkg.sv
// Shared constants of the interrupt route/prioritise/acknowledge block.
// Assumes a 32-bit AXI4-Lite register bus with a 12-bit byte address.
package irp_pkg;
  // ==========================================================
  // Priority and interrupt identifiers
  localparam int PRIO_W = 8;
  localparam logic [7:0] PRIO_IDLE = 8'hff;
  localparam int ID_W = 13;
  localparam logic [12:0] PPI_ID_BASE = 13'h010;
  localparam logic [12:0] SPI_ID_BASE = 13'h020;
  localparam logic [12:0] ESPI_ID_BASE = 13'h1000;
  localparam logic [12:0] ID_SEC_G1 = 13'h3fc;
  localparam logic [12:0] ID_NS_G1 = 13'h3fd;
  // Legacy-only identifier, never produced by this block
  localparam logic [12:0] ID_LEGACY = 13'h3fe;
  localparam logic [12:0] ID_SPURIOUS = 13'h3ff;
  // ==========================================================
  // Address map: window in addr[11:8], word in addr[7:2]
  localparam int ADDR_W = 12;
  localparam int WIN_LSB = 8;
  localparam int WORD_LSB = 2;
  localparam int CORE_LSB = 4;
  localparam logic [3:0] WIN_GLOB = 4'h0;
  localparam logic [3:0] WIN_CFG = 4'h1;
  localparam logic [3:0] WIN_ROUTE = 4'h2;
  localparam logic [3:0] WIN_CORE = 4'h3;
  localparam logic [7:0] OFS_DIST_CTRL = 8'h00;
  localparam logic [7:0] OFS_SET_EN = 8'h04;
  localparam logic [7:0] OFS_CLR_EN = 8'h08;
  localparam logic [7:0] OFS_SGI_GEN = 8'h0c;
  localparam logic [3:0] OFS_CORE_CTRL = 4'h0;
  localparam logic [3:0] OFS_ACK0 = 4'h4;
  localparam logic [3:0] OFS_ACK1 = 4'h8;
  localparam logic [3:0] OFS_EOI_RPR = 4'hc;
  // ==========================================================
  // Field positions
  localparam int CFG_GRP = 8;
  localparam int CFG_GMOD = 9;
  localparam int CFG_EDGE = 10;
  localparam int CFG_RANY = 11;
  localparam int CFG_EN = 12;
  localparam int CFG_PEND = 13;
  localparam int CFG_ACT = 14;
  localparam int CC_SLEEP = 0;
  localparam int CC_OPT = 1;
  localparam int CC_CEN = 4;
  localparam int CC_PMR = 8;
  localparam int SGI_TGT = 16;
  localparam int SGI_NUM_W = 4;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  typedef enum logic [1:0] {
    IRP_GRP0 = 2'b00,
    IRP_GRP1S = 2'b01,
    IRP_GRP1NS = 2'b10
  } irp_grp_t;
endpackage

// ===== pkg/irp_reg_if.sv
// Internal register access carrier between the bus slave and the core logic.
// Assumes one clock; strobes are single-cycle pulses.
`timescale 1ns/1ps
interface irp_reg_if;
  import irp_pkg::*;
  logic wr;
  logic [ADDR_W-1:0] waddr;
  logic [31:0] wdata;
  logic [3:0] wstrb;
  logic werr;
  logic rd;
  logic [ADDR_W-1:0] raddr;
  logic [31:0] rdata;
  logic rerr;
  modport bus (output wr, waddr, wdata, wstrb, rd, raddr, input werr, rdata, rerr);
  modport regs (input wr, waddr, wdata, wstrb, rd, raddr, output werr, rdata, rerr);
endinterface

// ===== src/irp_axil_slave.sv
// AXI4-Lite slave that turns bus transfers into register strobes.
// Assumes the register side answers reads combinationally in the strobe cycle.
`timescale 1ns/1ps
module irp_axil_slave (
  input wire logic aclk,
  input wire logic aresetn,
  irp_reg_if.bus rif,
  input wire logic [irp_pkg::ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [irp_pkg::ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  import irp_pkg::*;
  typedef struct packed {
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] addr;
    logic [31:0] data;
    logic [3:0] strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } irp_axs_t;
  irp_axs_t st_r, st_nxt;

  assign awready = !st_r.aw_got && !st_r.bvalid;
  assign wready = !st_r.w_got && !st_r.bvalid;
  assign arready = !st_r.rvalid;
  assign bvalid = st_r.bvalid;
  assign bresp = st_r.bresp;
  assign rvalid = st_r.rvalid;
  assign rdata = st_r.rdata;
  assign rresp = st_r.rresp;
  assign rif.wr = st_r.aw_got && st_r.w_got && !st_r.bvalid;
  assign rif.waddr = st_r.addr;
  assign rif.wdata = st_r.data;
  assign rif.wstrb = st_r.strb;
  assign rif.rd = arvalid && !st_r.rvalid;
  assign rif.raddr = araddr;

  always_comb begin
    st_nxt = st_r;
    // Address and data are latched independently, in either order
    if (awvalid && awready) begin
      st_nxt.aw_got = 1'b1;
      st_nxt.addr = awaddr;
    end
    if (wvalid && wready) begin
      st_nxt.w_got = 1'b1;
      st_nxt.data = wdata;
      st_nxt.strb = wstrb;
    end
    if (rif.wr) begin
      st_nxt.aw_got = 1'b0;
      st_nxt.w_got = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = rif.werr ? RESP_SLVERR : RESP_OKAY;
    end
    if (st_r.bvalid && bready) begin
      st_nxt.bvalid = 1'b0;
    end
    if (rif.rd) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rdata = rif.rdata;
      st_nxt.rresp = rif.rerr ? RESP_SLVERR : RESP_OKAY;
    end
    if (st_r.rvalid && rready) begin
      st_nxt.rvalid = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end
endmodule

// ===== src/irp_pick_min.sv
// Picks the most urgent candidate: lowest priority value, then lowest index.
// Purely combinational; assumes N fits in IW bits.
`timescale 1ns/1ps
module irp_pick_min #(
  parameter int N = 4,
  parameter int IW = 2
) (
  input wire logic [N-1:0] cand,
  input wire logic [N-1:0][irp_pkg::PRIO_W-1:0] prio,
  output logic found,
  output logic [IW-1:0] idx
);
  import irp_pkg::*;
  logic [PRIO_W-1:0] best;
  always_comb begin
    found = 1'b0;
    idx = '0;
    best = PRIO_IDLE;
    for (int i = 0; i < N; i++) begin
      // Strict compare keeps the earlier index on a tie
      if (cand[i] && (!found || prio[i] < best)) begin
        found = 1'b1;
        idx = IW'(i);
        best = prio[i];
      end
    end
  end
endmodule

// ===== src/irp_top.sv
// Interrupt configuration, routing, priority selection and acknowledge.
// Assumes a single clock, software on the AXI4-Lite port, sources synchronous.
// What this block does
// - Every interrupt holds an 8-bit priority; zero is most urgent.
// - Implemented priority bits are a parameter; unimplemented low bits read zero.
// - Group bit plus modifier bit place an interrupt in one of three groups.
// - Private and shared peripheral interrupts choose edge or level detection.
// - Software interrupts are always edge; their trigger bit reads one.
// - One enable per interrupt, changed through set and clear words.
// - Extended shared range uses the same register layout as the original.
// - Fixed-route shared interrupt goes only to the core matching its affinity.
// - Any-route shared interrupt goes to a participating core, rotating choice.
// - Each core has three group opt-out bits for any-route selection.
// - Disabled group blocks signalling; the interrupt stays pending.
// - Disabled interrupts still go pending but are never forwarded.
// - Private interrupts reach own core; software ones only listed targets.
// - Signal only interrupts strictly more urgent than the core mask.
// - Idle running priority is 0xFF; only more urgent ones preempt.
// - Forwarded interrupt shows as normal or fast request per core.
// - Each core has a group 0 and a group 1 acknowledge word.
// - Acknowledge read returns the id and moves the interrupt to active.
// - Group 0 read at top level returns 1020 for secure group 1.
// - Group 0 read at top level returns 1021 for non-secure group 1.
// - 1023 when nothing eligible; reserved ids acknowledge nothing.
// - Distributor holds separate enables for the three groups.
// - Cores start asleep; only awake cores receive interrupts.
// - Acknowledge raises running priority; end-of-interrupt restores it.
//
// The AXI4-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/1ps
module irp_top #(
  parameter int NC = 2,
  parameter int NSGI = 2,
  parameter int NPPI = 2,
  parameter int NSPI = 4,
  parameter int NESPI = 1,
  parameter int PRIO_BITS = 8,
  parameter int DEPTH = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [irp_pkg::ADDR_W-1:0] s_axil_awaddr,
  input wire logic s_axil_awvalid,
  output logic s_axil_awready,
  input wire logic [31:0] s_axil_wdata,
  input wire logic [3:0] s_axil_wstrb,
  input wire logic s_axil_wvalid,
  output logic s_axil_wready,
  output logic [1:0] s_axil_bresp,
  output logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [irp_pkg::ADDR_W-1:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  output logic s_axil_arready,
  output logic [31:0] s_axil_rdata,
  output logic [1:0] s_axil_rresp,
  output logic s_axil_rvalid,
  input wire logic s_axil_rready,
  input wire logic [NC*NPPI-1:0] ppi_src,
  input wire logic [NSPI-1:0] spi_src,
  input wire logic [NC-1:0][31:0] core_affinity,
  input wire logic [NC-1:0] core_top_el,
  output logic [NC-1:0] irq,
  output logic [NC-1:0] fast_interrupt_request
);
  import irp_pkg::*;
  localparam int NPRIV = NSGI + NPPI;
  localparam int SPI0 = NC * NPRIV;
  localparam int NSRC = SPI0 + NSPI;
  localparam int SW = $clog2(NSRC);
  localparam int CW = (NC > 1) ? $clog2(NC) : 1;
  localparam int DW = $clog2(DEPTH + 1);
  // Unimplemented low priority bits are forced to zero
  localparam logic [7:0] PMASK = 8'(PRIO_IDLE << (PRIO_W - PRIO_BITS));

  // ==========================================================
  // State
  typedef struct packed {
    logic [2:0] dctl;
    logic [NSRC-1:0][PRIO_W-1:0] prio;
    logic [NSRC-1:0] grp;
    logic [NSRC-1:0] gmod;
    logic [NSRC-1:0] trig_edge;
    logic [NSRC-1:0] en;
    logic [NSRC-1:0] pend;
    logic [NSRC-1:0] act;
    logic [NSRC-1:0] src_q;
    logic [NSPI-1:0] rany;
    logic [NSPI-1:0][31:0] aff;
    logic [NC-1:0] sleep;
    logic [NC-1:0][2:0] opt;
    logic [NC-1:0][2:0] cen;
    logic [NC-1:0][PRIO_W-1:0] pmr;
    logic [NC-1:0][DW-1:0] sp;
    logic [NC-1:0][DEPTH-1:0][SW-1:0] stk_src;
    logic [NC-1:0][DEPTH-1:0][PRIO_W-1:0] stk_pri;
    logic [CW-1:0] rr;
    logic [NC-1:0] irq;
    logic [NC-1:0] fast_interrupt_request;
  } irp_st_t;
  irp_st_t st_r, st_nxt;

  irp_reg_if rif();

  logic [NC-1:0][NSRC-1:0] cand;
  logic [NC-1:0] found;
  logic [NC-1:0][SW-1:0] best;
  logic [NC-1:0][PRIO_W-1:0] rpr;
  logic [NC-1:0][1:0][ID_W-1:0] ack_id;
  logic [NC-1:0][1:0] ack_ok;
  logic [2:0][CW-1:0] any_tgt;
  logic [2:0] any_ok;
  logic [31:0] wcur;
  logic wcur_err;
  logic rd_err;

  // ==========================================================
  // Decoding helpers
  function automatic irp_grp_t grp_of(input logic g, input logic m);
    case ({m, g})
      2'b00: grp_of = IRP_GRP0;
      2'b10: grp_of = IRP_GRP1S;
      default: grp_of = IRP_GRP1NS;
    endcase
  endfunction

  function automatic logic is_sgi(input int i);
    is_sgi = (i < SPI0) && ((i % NPRIV) < NSGI);
  endfunction

  function automatic logic [ID_W-1:0] src_id(input int i);
    int k;
    k = i - SPI0;
    if (i >= SPI0) begin
      // Extended range shares the layout, only the id differs
      if (k < NSPI - NESPI) begin
        src_id = SPI_ID_BASE + ID_W'(k);
      end else begin
        src_id = ESPI_ID_BASE + ID_W'(k - (NSPI - NESPI));
      end
    end else if ((i % NPRIV) < NSGI) begin
      src_id = ID_W'(i % NPRIV);
    end else begin
      src_id = PPI_ID_BASE + ID_W'((i % NPRIV) - NSGI);
    end
  endfunction

  function automatic logic [31:0] rd_word(input logic [ADDR_W-1:0] a, output logic err);
    int w;
    int c;
    w = int'(a[WIN_LSB-1:WORD_LSB]);
    c = int'(a[WIN_LSB-1:CORE_LSB]);
    err = 1'b0;
    rd_word = '0;
    case (a[ADDR_W-1:WIN_LSB])
      WIN_GLOB: begin
        case (a[WIN_LSB-1:0])
          OFS_DIST_CTRL: rd_word = 32'(st_r.dctl);
          OFS_SET_EN, OFS_CLR_EN: rd_word = 32'(st_r.en);
          OFS_SGI_GEN: rd_word = '0;
          default: err = 1'b1;
        endcase
      end
      WIN_CFG: begin
        if (w < NSRC) begin
          rd_word[PRIO_W-1:0] = st_r.prio[w];
          rd_word[CFG_GRP] = st_r.grp[w];
          rd_word[CFG_GMOD] = st_r.gmod[w];
          rd_word[CFG_EDGE] = st_r.trig_edge[w] | is_sgi(w);
          rd_word[CFG_RANY] = (w >= SPI0) ? st_r.rany[w-SPI0] : 1'b0;
          rd_word[CFG_EN] = st_r.en[w];
          rd_word[CFG_PEND] = st_r.pend[w];
          rd_word[CFG_ACT] = st_r.act[w];
        end else begin
          err = 1'b1;
        end
      end
      WIN_ROUTE: begin
        if (w < NSPI) begin
          rd_word = st_r.aff[w];
        end else begin
          err = 1'b1;
        end
      end
      WIN_CORE: begin
        if (c < NC) begin
          case (a[CORE_LSB-1:0])
            OFS_CORE_CTRL: begin
              rd_word[CC_SLEEP] = st_r.sleep[c];
              rd_word[CC_OPT +: 3] = st_r.opt[c];
              rd_word[CC_CEN +: 3] = st_r.cen[c];
              rd_word[CC_PMR +: PRIO_W] = st_r.pmr[c];
            end
            OFS_ACK0: rd_word = 32'(ack_id[c][0]);
            OFS_ACK1: rd_word = 32'(ack_id[c][1]);
            OFS_EOI_RPR: rd_word = 32'(rpr[c]);
            default: err = 1'b1;
          endcase
        end else begin
          err = 1'b1;
        end
      end
      default: err = 1'b1;
    endcase
  endfunction

  // ==========================================================
  // Bus slave and register read port
  irp_axil_slave u_axil (
    .aclk(aclk),
    .aresetn(aresetn),
    .rif(rif),
    .awaddr(s_axil_awaddr),
    .awvalid(s_axil_awvalid),
    .awready(s_axil_awready),
    .wdata(s_axil_wdata),
    .wstrb(s_axil_wstrb),
    .wvalid(s_axil_wvalid),
    .wready(s_axil_wready),
    .bresp(s_axil_bresp),
    .bvalid(s_axil_bvalid),
    .bready(s_axil_bready),
    .araddr(s_axil_araddr),
    .arvalid(s_axil_arvalid),
    .arready(s_axil_arready),
    .rdata(s_axil_rdata),
    .rresp(s_axil_rresp),
    .rvalid(s_axil_rvalid),
    .rready(s_axil_rready)
  );

  always_comb begin
    rif.rdata = rd_word(rif.raddr, rd_err);
    rif.rerr = rd_err;
    wcur = rd_word(rif.waddr, wcur_err);
    rif.werr = wcur_err;
  end

  // ==========================================================
  // Forwarding tests
  always_comb begin
    for (int c = 0; c < NC; c++) begin
      rpr[c] = (st_r.sp[c] == '0) ? PRIO_IDLE : st_r.stk_pri[c][st_r.sp[c]-1'b1];
    end
  end

  // Rotating start point spreads any-route interrupts over the cores
  always_comb begin
    int c;
    c = 0;
    any_ok = '0;
    any_tgt = '0;
    for (int g = 0; g < 3; g++) begin
      for (int i = NC - 1; i >= 0; i--) begin
        c = (int'(st_r.rr) + i) % NC;
        if (!st_r.sleep[c] && st_r.cen[c][g] && !st_r.opt[c][g] && st_r.dctl[g]) begin
          any_ok[g] = 1'b1;
          any_tgt[g] = CW'(c);
        end
      end
    end
  end

  always_comb begin
    int g;
    logic route;
    g = 0;
    route = 1'b0;
    cand = '0;
    for (int c = 0; c < NC; c++) begin
      for (int i = 0; i < NSRC; i++) begin
        g = int'(grp_of(st_r.grp[i], st_r.gmod[i]));
        if (i < SPI0) begin
          route = (i / NPRIV) == c;
        end else if (st_r.rany[i-SPI0]) begin
          route = any_ok[g] && (int'(any_tgt[g]) == c);
        end else begin
          route = st_r.aff[i-SPI0] == core_affinity[c];
        end
        cand[c][i] = st_r.pend[i] && st_r.en[i] && !st_r.act[i]
          && st_r.dctl[g] && st_r.cen[c][g]
          && !st_r.sleep[c] && route
          && (st_r.prio[i] < st_r.pmr[c])
          && (st_r.prio[i] < rpr[c])
          && (int'(st_r.sp[c]) < DEPTH);
      end
    end
  end

  for (genvar c = 0; c < NC; c++) begin : g_pick
    irp_pick_min #(
      .N(NSRC),
      .IW(SW)
    ) u_pick (
      .cand(cand[c]),
      .prio(st_r.prio),
      .found(found[c]),
      .idx(best[c])
    );
  end

  // ==========================================================
  // Acknowledge answers
  always_comb begin
    irp_grp_t bg;
    logic [ID_W-1:0] id;
    bg = IRP_GRP0;
    id = '0;
    for (int c = 0; c < NC; c++) begin
      bg = grp_of(st_r.grp[best[c]], st_r.gmod[best[c]]);
      id = src_id(int'(best[c]));
      ack_id[c] = {ID_SPURIOUS, ID_SPURIOUS};
      ack_ok[c] = '0;
      if (found[c]) begin
        if (bg == IRP_GRP0) begin
          ack_id[c][0] = id;
          ack_ok[c][0] = 1'b1;
        end else begin
          ack_id[c][1] = id;
          ack_ok[c][1] = 1'b1;
          if (core_top_el[c]) begin
            ack_id[c][0] = (bg == IRP_GRP1S) ? ID_SEC_G1 : ID_NS_G1;
          end
        end
      end
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    logic [31:0] m;
    logic [31:0] wv;
    logic [31:0] wm;
    logic lvl;
    logic edge_mode;
    int w;
    int c;
    int b;
    int ws;
    m = {{8{rif.wstrb[3]}}, {8{rif.wstrb[2]}}, {8{rif.wstrb[1]}}, {8{rif.wstrb[0]}}};
    wv = (wcur & ~m) | (rif.wdata & m);
    wm = rif.wdata & m;
    lvl = 1'b0;
    edge_mode = 1'b0;
    w = int'(rif.waddr[WIN_LSB-1:WORD_LSB]);
    c = int'(rif.waddr[WIN_LSB-1:CORE_LSB]);
    b = 0;
    ws = int'(wm[SGI_NUM_W-1:0]);
    st_nxt = st_r;
    if (rif.wr && !rif.werr) begin
      case (rif.waddr[ADDR_W-1:WIN_LSB])
        WIN_GLOB: begin
          case (rif.waddr[WIN_LSB-1:0])
            OFS_DIST_CTRL: st_nxt.dctl = wv[2:0];
            OFS_SET_EN: st_nxt.en = st_r.en | wm[NSRC-1:0];
            OFS_CLR_EN: st_nxt.en = st_r.en & ~wm[NSRC-1:0];
            default: begin
            end
          endcase
        end
        WIN_CFG: begin
          st_nxt.prio[w] = wv[PRIO_W-1:0] & PMASK;
          st_nxt.grp[w] = wv[CFG_GRP];
          st_nxt.gmod[w] = wv[CFG_GMOD];
          if (!is_sgi(w)) begin
            st_nxt.trig_edge[w] = wv[CFG_EDGE];
          end
          if (w >= SPI0) begin
            st_nxt.rany[w-SPI0] = wv[CFG_RANY];
          end
        end
        WIN_ROUTE: st_nxt.aff[w] = wv;
        WIN_CORE: begin
          if (rif.waddr[CORE_LSB-1:0] == OFS_CORE_CTRL) begin
            st_nxt.sleep[c] = wv[CC_SLEEP];
            st_nxt.opt[c] = wv[CC_OPT +: 3];
            st_nxt.cen[c] = wv[CC_CEN +: 3];
            st_nxt.pmr[c] = wv[CC_PMR +: PRIO_W] & PMASK;
          end
          if (rif.waddr[CORE_LSB-1:0] == OFS_EOI_RPR && st_r.sp[c] != '0) begin
            st_nxt.act[st_r.stk_src[c][st_r.sp[c]-1'b1]] = 1'b0;
            st_nxt.sp[c] = st_r.sp[c] - 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    // Acknowledge may follow an end-of-interrupt in the same cycle
    c = int'(rif.raddr[WIN_LSB-1:CORE_LSB]);
    if (rif.rd && !rif.rerr && rif.raddr[ADDR_W-1:WIN_LSB] == WIN_CORE
        && (rif.raddr[CORE_LSB-1:0] == OFS_ACK0 || rif.raddr[CORE_LSB-1:0] == OFS_ACK1)) begin
      if (ack_ok[c][rif.raddr[CORE_LSB-1:0] == OFS_ACK1]) begin
        b = int'(best[c]);
        st_nxt.pend[b] = 1'b0;
        st_nxt.act[b] = 1'b1;
        st_nxt.stk_src[c][st_nxt.sp[c]] = best[c];
        st_nxt.stk_pri[c][st_nxt.sp[c]] = st_r.prio[b];
        st_nxt.sp[c] = st_nxt.sp[c] + 1'b1;
        if (b >= SPI0 && st_r.rany[b-SPI0]) begin
          st_nxt.rr = (int'(st_r.rr) == NC - 1) ? '0 : st_r.rr + 1'b1;
        end
      end
    end
    // Pending sets come last so a new event beats a same-cycle acknowledge
    for (int i = 0; i < NSRC; i++) begin
      if (i >= SPI0) begin
        lvl = spi_src[i-SPI0];
      end else if (!is_sgi(i)) begin
        lvl = ppi_src[(i / NPRIV) * NPPI + (i % NPRIV) - NSGI];
      end else begin
        lvl = 1'b0;
      end
      st_nxt.src_q[i] = lvl;
      edge_mode = st_r.trig_edge[i] | is_sgi(i);
      if (edge_mode) begin
        if (lvl && !st_r.src_q[i]) begin
          st_nxt.pend[i] = 1'b1;
        end
      end else begin
        st_nxt.pend[i] = lvl && !st_nxt.act[i];
      end
    end
    if (rif.wr && !rif.werr && rif.waddr[ADDR_W-1:WIN_LSB] == WIN_GLOB
        && rif.waddr[WIN_LSB-1:0] == OFS_SGI_GEN && ws < NSGI) begin
      for (int t = 0; t < NC; t++) begin
        if (wm[SGI_TGT + t]) begin
          st_nxt.pend[t * NPRIV + ws] = 1'b1;
        end
      end
    end
    // Group 0 and secure group 1 use the fast request line
    for (int t = 0; t < NC; t++) begin
      st_nxt.fast_interrupt_request[t] = found[t] && ack_ok[t][0] | (found[t] && ack_ok[t][1]
        && grp_of(st_r.grp[best[t]], st_r.gmod[best[t]]) == IRP_GRP1S);
      st_nxt.irq[t] = found[t] && grp_of(st_r.grp[best[t]], st_r.gmod[best[t]])
        == IRP_GRP1NS;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= '0;
      st_r.sleep <= '1;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign irq = st_r.irq;
  assign fast_interrupt_request = st_r.fast_interrupt_request;
endmodule

// ===== testbench/irp_top_monitor.sv
// Port checker for irp_top: bus answers, acknowledge codes, request lines.
// Assumes it is bound to irp_top and sees only its ports.
`timescale 1ns/1ps
module irp_top_monitor #(
  parameter int NC = 2
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axil_bvalid,
  input wire logic s_axil_bready,
  input wire logic [irp_pkg::ADDR_W-1:0] s_axil_araddr,
  input wire logic s_axil_arvalid,
  input wire logic s_axil_arready,
  input wire logic [31:0] s_axil_rdata,
  input wire logic s_axil_rvalid,
  input wire logic s_axil_rready,
  input wire logic [NC-1:0] core_top_el,
  input wire logic [NC-1:0] irq,
  input wire logic [NC-1:0] fast_interrupt_request
);
  import irp_pkg::*;
  // ==========================================================
  // Address of the read whose answer stands
  logic [ADDR_W-1:0] ar_r;
  logic [ADDR_W-1:0] ar_nxt;
  logic ack0;
  logic ack1;
  always_comb ar_nxt = (s_axil_arvalid && s_axil_arready) ? s_axil_araddr : ar_r;
  always_ff @(posedge aclk) ar_r <= ar_nxt;
  assign ack0 = s_axil_rvalid && ar_r[11:8] == WIN_CORE && ar_r[3:0] == OFS_ACK0;
  assign ack1 = s_axil_rvalid && ar_r[11:8] == WIN_CORE && ar_r[3:0] == OFS_ACK1;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ==========================================================
  one_kind_a: assert property ((irq & fast_interrupt_request) == '0)
    else $error("irq and fiq high together");
  quiet_reset_a: assert property ($rose(aresetn) |-> irq == '0 && fast_interrupt_request == '0)
    else $error("request line high after reset");
  read_answer_a: assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid)
    else $error("read not answered");
  read_hold_a: assert property (s_axil_rvalid && !s_axil_rready
    |=> s_axil_rvalid && $stable(s_axil_rdata)) else $error("read answer dropped");
  write_hold_a: assert property (s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid)
    else $error("write answer dropped");
  no_legacy_a: assert property (ack0 || ack1 |-> s_axil_rdata != 32'h3fe)
    else $error("legacy id returned");
  grp1_codes_a: assert property (ack1 |-> !(s_axil_rdata inside {32'h3fc, 32'h3fd}))
    else $error("group 1 ack gave 1020 or 1021");
  top_level_a: assert property (ack0 && !core_top_el[ar_r[7:4]]
    |-> !(s_axil_rdata inside {32'h3fc, 32'h3fd})) else $error("low level got 1020 or 1021");
endmodule
bind irp_top irp_top_monitor #(.NC(NC)) mon (.*);

// ===== testbench/irp_core_model.sv
// Processor cores on the far side: fixed affinity words, steered level.
// Assumes the bench changes the level only between reads.
`timescale 1ns/1ps
module irp_core_model #(
  parameter int NC = 2
) (
  input wire logic [NC-1:0] top_el_req,
  output logic [NC-1:0][31:0] core_affinity,
  output logic [NC-1:0] core_top_el
);
  // Core c answers to affinity 0x11 + 0x100*c
  always_comb begin
    for (int c = 0; c < NC; c++) begin
      core_affinity[c] = 32'h11 + 32'(c) * 32'h100;
    end
  end
  // Combinational so the level is settled at the edge the read is taken
  assign core_top_el = top_el_req;
endmodule

// ===== testbench/irp_top_tb.sv
// Bench for irp_top: bus tasks queue expected reads, a watcher compares.
// Assumes the core model gives affinity 0x111 to core 1.
`timescale 1ns/1ps
module irp_top_tb;
  import irp_pkg::*;
  logic aclk = 0;
  logic aresetn = 0;
  logic s_axil_awvalid = 0, s_axil_wvalid = 0, s_axil_bready = 0;
  logic s_axil_arvalid = 0, s_axil_rready = 0;
  logic s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
  logic [11:0] s_axil_awaddr = 0, s_axil_araddr = 0;
  logic [31:0] s_axil_wdata = 0, s_axil_rdata;
  logic [1:0] s_axil_bresp, s_axil_rresp, core_top_el, irq, fast_interrupt_request, top_el_req = 0;
  logic [3:0] s_axil_wstrb = 4'hf, spi_src = 0, ppi_src = 0;
  logic [1:0][31:0] core_affinity;
  logic [33:0] exp_q[$];
  logic [7:0] pr;
  int checks = 0, num_errors = 0;
  always #10 aclk = ~aclk;
  irp_top DUT (.*);
  irp_core_model #(.NC(2)) cores (.top_el_req(top_el_req), .core_affinity(core_affinity),
    .core_top_el(core_top_el));
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] s);
    checks++;
    if (s !== e) begin
      num_errors++;
      $display("BAD %s exp %h got %h", nm, e, s);
    end
  endtask
  task automatic final_report;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    s_axil_awaddr <= a;
    s_axil_wdata <= d;
    s_axil_awvalid <= 1'b1;
    s_axil_wvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axil_awready) s_axil_awvalid <= 1'b0;
      if (s_axil_wready) s_axil_wvalid <= 1'b0;
      n++;
    end while (!s_axil_bvalid && n < 50);
    // Ready trails valid by one edge so a waiting answer is exercised
    s_axil_bready <= 1'b1;
    @(posedge aclk);
    chk("bresp", 34'h0, 34'(s_axil_bresp));
    s_axil_bready <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      final_report();
    end
  endtask
  task automatic rd(input logic [11:0] a, input logic [33:0] e);
    int n = 0;
    exp_q.push_back(e);
    s_axil_araddr <= a;
    s_axil_arvalid <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axil_arready) s_axil_arvalid <= 1'b0;
      n++;
    end while (!s_axil_rvalid && n < 50);
    s_axil_rready <= 1'b1;
    @(posedge aclk);
    s_axil_rready <= 1'b0;
    if (n >= 50) begin
      num_errors++;
      final_report();
    end
  endtask
  // Request lines move two cycles after their cause, four cycles settle them
  task automatic pins(input logic [3:0] e);
    repeat (4) @(posedge aclk);
    chk("irq_fiq", {30'h0, e}, {30'h0, irq, fast_interrupt_request});
  endtask
  always @(posedge aclk) begin
    if (s_axil_rvalid && s_axil_rready) begin
      if (exp_q.size() == 0) chk("rd_extra", 34'h0, 34'h1);
      else chk("rd", exp_q.pop_front(), {s_axil_rresp, s_axil_rdata});
    end
  end
  initial begin
    void'($urandom(32'h251c588b));
    pr = 8'h01 + 8'($urandom % 126);
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    wr(12'h100, 32'h0);
    rd(12'h100, 34'h400);
    rd(12'h31c, 34'hff);
    rd(12'h300, 34'h1);
    rd(12'h314, 34'h3ff);
    rd(12'h400, {RESP_SLVERR, 32'h0});
    wr(12'h120, {23'h0, 1'b1, pr});
    wr(12'h200, 32'h111);
    wr(12'h000, 32'h7);
    wr(12'h300, 32'h8070);
    wr(12'h310, 32'h8070);
    spi_src <= 4'h1;
    pins(4'h0);
    rd(12'h120, 34'h2100 | 34'(pr));
    wr(12'h004, 32'h100);
    pins(4'h8);
    wr(12'h310, {16'h0, pr, 8'h70});
    pins(4'h0);
    wr(12'h310, 32'h8070);
    wr(12'h000, 32'h3);
    pins(4'h0);
    wr(12'h000, 32'h7);
    top_el_req <= 2'b10;
    rd(12'h314, 34'h3fd);
    top_el_req <= 2'b00;
    rd(12'h314, 34'h3ff);
    rd(12'h318, 34'h20);
    rd(12'h31c, 34'(pr));
    rd(12'h318, 34'h3ff);
    wr(12'h31c, 32'h0);
    rd(12'h31c, 34'hff);
    wr(12'h008, 32'h100);
    wr(12'h120, {24'h0, pr});
    wr(12'h004, 32'h100);
    pins(4'h2);
    rd(12'h314, 34'h20);
    wr(12'h004, 32'h1);
    wr(12'h00c, 32'h10000);
    pins(4'h1);
    rd(12'h304, 34'h0);
    final_report();
  end
endmodule
